/* File: rtl/afsa_cfg.svh */
// Constants for the alarm and shutdown annunciator.
//
// Behaviour
// RQ1: Shutdown view shown only while a shutdown latched.
// RQ2: Alarm view shown only while an alarm latched.
// RQ3: First-out shutdown code holds earliest latched shutdown.
// RQ4: Separate first-out alarm code holds earliest alarm.
// RQ5: Fault conditions numbered one to eleven, fixed order.
// RQ6: Shutdown latches only when its enable bit set.
// RQ7: Alarm latches only when its own enable set.
// RQ8: Reset clears a latch only once cause gone.
// RQ9: Reset comes from discrete, serial, service, handheld.
// RQ10: One reset acts on all latches together.
// RQ11: Requester drives true then false; act once.
// RQ12: Relay polarity chooses energize or de-energize on alarm.
// RQ13: Trip-on-warning makes any alarm shut actuator down.
// RQ14: Reset clearing all latches also clears first-out.
// RQ15: Simultaneous first events record the lowest code.
`ifndef AFSA_CFG_SVH
`define AFSA_CFG_SVH

// ------------------------------------------------------------
// Sizes
// ------------------------------------------------------------
`define AFSA_NUM_FAULTS 11
`define AFSA_CODE_W 4
`define AFSA_ADDR_W 8
`define AFSA_DATA_W 32
`define AFSA_NUM_SOURCES 4

// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define AFSA_OFS_TRIP_EN 8'h00
`define AFSA_OFS_WARN_EN 8'h04
`define AFSA_OFS_CTRL 8'h08
`define AFSA_OFS_TRIP_LATCH 8'h0C
`define AFSA_OFS_WARN_LATCH 8'h10
`define AFSA_OFS_FIRST_OUT 8'h14
`define AFSA_OFS_LIVE 8'h18

// ------------------------------------------------------------
// Field positions and reset values
// ------------------------------------------------------------
`define AFSA_CTRL_RELAY_POL 0
`define AFSA_CTRL_TRIP_ON_WARN 1
`define AFSA_CTRL_RESET_CMD 2
`define AFSA_FO_TRIP_LSB 0
`define AFSA_FO_WARN_LSB 8
`define AFSA_FO_TRIP_VIEW 16
`define AFSA_FO_WARN_VIEW 17
`define AFSA_SRC_DISCRETE 0
`define AFSA_SRC_SERIAL 1
`define AFSA_SRC_SERVICE 2
`define AFSA_SRC_HANDHELD 3
`define AFSA_EN_RESET 11'h000
`define AFSA_CODE_NONE 4'h0

`endif

/* File: rtl/afsa_pkg.sv */
// Types shared by the alarm and shutdown annunciator.
package afsa_pkg;

	typedef logic [10:0] afsa_fault_vec_t;
	typedef logic [3:0] afsa_code_t;

	// Condition codes as shown on the first-out indicators.
	typedef enum logic [3:0] {
		AFSA_NONE = 4'b0000,
		AFSA_SPEED1 = 4'b0001,
		AFSA_SPEED2 = 4'b0010,
		AFSA_BOTH_SPEED = 4'b0011,
		AFSA_REMOTE_IN = 4'b0100,
		AFSA_FUEL_CAP = 4'b0101,
		AFSA_SERIAL2 = 4'b0110,
		AFSA_SERIAL3 = 4'b0111,
		AFSA_LINK = 4'b1000,
		AFSA_FUEL_DEMAND = 4'b1001,
		AFSA_OVERSPEED = 4'b1010,
		AFSA_TORSION = 4'b1011
	} afsa_fault_code_t;

endpackage : afsa_pkg

/* File: rtl/afsa_sync.sv */
// Two-stage synchroniser for asynchronous pin levels.
`timescale 1ns/100ps
module afsa_sync #(
	parameter int WIDTH = 12
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] stage1_reg;

	always_ff @(posedge clk) begin
		if (!resetn) begin
			stage1_reg <= '0;
			sync_out <= '0;
		end else begin
			stage1_reg <= async_in;
			sync_out <= stage1_reg;
		end
	end

endmodule : afsa_sync

/* File: rtl/afsa_release_detect.sv */
// Detects a true-then-false sequence on each reset command source.
`timescale 1ns/100ps
module afsa_release_detect #(
	parameter int WIDTH = 4
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic [WIDTH-1:0] level_in,
	output logic [WIDTH-1:0] release_pulse
);

	logic [WIDTH-1:0] prev_reg;

	// A command acts once, on its return to false, so a held-true command
	// cannot keep clearing latches.
	assign release_pulse = prev_reg & ~level_in; // RQ11

	always_ff @(posedge clk) begin
		if (!resetn) begin
			prev_reg <= '0;
		end else begin
			prev_reg <= level_in;
		end
	end

endmodule : afsa_release_detect

/* File: rtl/afsa_annunciator.sv */
// Latching alarm and shutdown annunciator with first-out capture.
//
// The register addresses and the strobed register port are this design's own decisions.
`timescale 1ns/100ps
`include "afsa_cfg.svh"
module afsa_annunciator (
	input wire logic SYS_CLK,
	input wire logic RESETN,
	input wire logic [`AFSA_NUM_FAULTS-1:0] FAULT_IN,
	input wire logic RESET_PIN,
	input wire logic SERIAL_RESET_CMD,
	input wire logic SERVICE_RESET_CMD,
	input wire logic [`AFSA_ADDR_W-1:0] ADDR,
	input wire logic [`AFSA_DATA_W-1:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [`AFSA_DATA_W-1:0] RDATA,
	output logic TRIP_VIEW,
	output logic WARN_VIEW,
	output logic [`AFSA_CODE_W-1:0] FIRST_TRIP,
	output logic [`AFSA_CODE_W-1:0] FIRST_WARN,
	output logic [`AFSA_NUM_FAULTS-1:0] TRIP_LATCHED,
	output logic [`AFSA_NUM_FAULTS-1:0] WARN_LATCHED,
	output logic RELAY2_ENERGIZE,
	output logic ACTUATOR_SHUTDOWN
);

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------

	// Lowest set bit as a one-based condition code, zero when none.
	function automatic afsa_pkg::afsa_code_t lowest_code(
		input afsa_pkg::afsa_fault_vec_t vec
	);
		afsa_pkg::afsa_code_t code;
		code = `AFSA_CODE_NONE;
		for (int i = `AFSA_NUM_FAULTS - 1; i >= 0; i--) begin
			if (vec[i]) begin
				code = afsa_pkg::afsa_code_t'(i + 1); // RQ5
			end
		end
		return code; // RQ15
	endfunction : lowest_code

	// Next first-out code: cleared when the reset emptied the bank,
	// then loaded from the earliest new entries while empty.
	function automatic afsa_pkg::afsa_code_t next_first(
		input afsa_pkg::afsa_code_t cur,
		input afsa_pkg::afsa_fault_vec_t latch_now,
		input afsa_pkg::afsa_fault_vec_t latch_nxt,
		input logic reset_act
	);
		afsa_pkg::afsa_code_t base;
		afsa_pkg::afsa_fault_vec_t fresh;
		fresh = latch_nxt & ~latch_now;
		base = cur;
		if (reset_act && ((latch_now & latch_nxt) == `AFSA_EN_RESET)) begin
			base = `AFSA_CODE_NONE; // RQ14
		end
		if ((base == `AFSA_CODE_NONE) && (fresh != `AFSA_EN_RESET)) begin
			base = lowest_code(fresh);
		end
		return base;
	endfunction : next_first

	// Next latch bank: set wins over reset, and reset only drops entries
	// whose cause is gone.
	function automatic afsa_pkg::afsa_fault_vec_t next_latch(
		input afsa_pkg::afsa_fault_vec_t cur,
		input afsa_pkg::afsa_fault_vec_t cause,
		input afsa_pkg::afsa_fault_vec_t enable,
		input logic reset_act
	);
		afsa_pkg::afsa_fault_vec_t keep;
		keep = reset_act ? (cur & cause) : cur; // RQ8
		return keep | (cause & enable);
	endfunction : next_latch

	// Places a fault vector in the low bits of a bus word; the upper bits
	// read as zero.
	function automatic logic [`AFSA_DATA_W-1:0] fault_word(
		input afsa_pkg::afsa_fault_vec_t vec
	);
		logic [`AFSA_DATA_W-1:0] word;
		word = '0;
		word[`AFSA_NUM_FAULTS-1:0] = vec;
		return word;
	endfunction : fault_word

	// ------------------------------------------------------------
	// Input synchronisation
	// ------------------------------------------------------------

	logic [`AFSA_NUM_FAULTS:0] pin_sync;
	afsa_pkg::afsa_fault_vec_t fault_live;
	logic reset_pin_live;

	// Fault lines and the discrete reset share one synchroniser bank.
	// A cause shorter than one clock may be missed; causes are expected to
	// be levels that last many cycles.
	afsa_sync #(
		.WIDTH(`AFSA_NUM_FAULTS + 1)
	) u_sync (
		.clk(SYS_CLK),
		.resetn(RESETN),
		.async_in({RESET_PIN, FAULT_IN}),
		.sync_out(pin_sync)
	);

	assign fault_live = pin_sync[`AFSA_NUM_FAULTS-1:0];
	assign reset_pin_live = pin_sync[`AFSA_NUM_FAULTS];

	// ------------------------------------------------------------
	// Configuration registers
	// ------------------------------------------------------------

	afsa_pkg::afsa_fault_vec_t trip_enable_config_reg;
	afsa_pkg::afsa_fault_vec_t warning_enable_config_reg;
	logic relay_polarity_reg;
	logic trip_on_warning_enable_reg;
	logic handheld_reset_reg;

	wire sel_trip_en = (ADDR == `AFSA_OFS_TRIP_EN);
	wire sel_warn_en = (ADDR == `AFSA_OFS_WARN_EN);
	wire sel_ctrl = (ADDR == `AFSA_OFS_CTRL);
	wire sel_trip_latch = (ADDR == `AFSA_OFS_TRIP_LATCH);
	wire sel_warn_latch = (ADDR == `AFSA_OFS_WARN_LATCH);
	wire sel_first_out = (ADDR == `AFSA_OFS_FIRST_OUT);
	wire sel_live = (ADDR == `AFSA_OFS_LIVE);

	wire wr_trip_en = WR && sel_trip_en;
	wire wr_warn_en = WR && sel_warn_en;
	wire wr_ctrl = WR && sel_ctrl;

	// Writes to unmapped or read-only words fall through unused. The
	// handheld command is a plain bit: software must write it true and then
	// false, and a write that leaves it true requests nothing further.

	always_ff @(posedge SYS_CLK) begin
		if (!RESETN) begin
			trip_enable_config_reg <= `AFSA_EN_RESET;
			warning_enable_config_reg <= `AFSA_EN_RESET;
			relay_polarity_reg <= 1'b0;
			trip_on_warning_enable_reg <= 1'b0;
			handheld_reset_reg <= 1'b0;
		end else begin
			if (wr_trip_en) begin
				trip_enable_config_reg <= WDATA[`AFSA_NUM_FAULTS-1:0];
			end
			if (wr_warn_en) begin
				warning_enable_config_reg <= WDATA[`AFSA_NUM_FAULTS-1:0];
			end
			if (wr_ctrl) begin
				relay_polarity_reg <= WDATA[`AFSA_CTRL_RELAY_POL];
				trip_on_warning_enable_reg <= WDATA[`AFSA_CTRL_TRIP_ON_WARN];
				handheld_reset_reg <= WDATA[`AFSA_CTRL_RESET_CMD];
			end
		end
	end

	// ------------------------------------------------------------
	// Reset command sources
	// ------------------------------------------------------------

	logic [`AFSA_NUM_SOURCES-1:0] source_level;
	logic [`AFSA_NUM_SOURCES-1:0] source_release;
	logic reset_act;

	// Serial and service commands come from logic on this clock already.
	always_comb begin
		source_level = '0;
		source_level[`AFSA_SRC_DISCRETE] = reset_pin_live; // RQ9
		source_level[`AFSA_SRC_SERIAL] = SERIAL_RESET_CMD; // RQ9
		source_level[`AFSA_SRC_SERVICE] = SERVICE_RESET_CMD; // RQ9
		source_level[`AFSA_SRC_HANDHELD] = handheld_reset_reg; // RQ9
	end

	afsa_release_detect #(
		.WIDTH(`AFSA_NUM_SOURCES)
	) u_release (
		.clk(SYS_CLK),
		.resetn(RESETN),
		.level_in(source_level),
		.release_pulse(source_release)
	);

	// Any source's release acts on both banks at once; releases that
	// coincide merge into one action, which is harmless.
	// The discrete pin reaches the detector two cycles after the command
	// links, so one request sent on several sources may act twice; the
	// second clear only drops entries whose cause has gone, as any reset.
	assign reset_act = |source_release; // RQ10

	// ------------------------------------------------------------
	// Latch banks
	// ------------------------------------------------------------

	afsa_pkg::afsa_fault_vec_t trip_latch_reg;
	afsa_pkg::afsa_fault_vec_t trip_latch_next;
	afsa_pkg::afsa_fault_vec_t warn_latch_reg;
	afsa_pkg::afsa_fault_vec_t warn_latch_next;
	afsa_pkg::afsa_code_t first_trip_reg;
	afsa_pkg::afsa_code_t first_trip_next;
	afsa_pkg::afsa_code_t first_warn_reg;
	afsa_pkg::afsa_code_t first_warn_next;

	// The two banks see the same causes but independent enables.
	assign trip_latch_next = next_latch(trip_latch_reg, fault_live,
		trip_enable_config_reg, reset_act); // RQ6
	assign warn_latch_next = next_latch(warn_latch_reg, fault_live,
		warning_enable_config_reg, reset_act); // RQ7

	// First-out follows the stored bank, so a code stays held while its
	// entry is hidden by a cleared enable.
	assign first_trip_next = next_first(first_trip_reg, trip_latch_reg,
		trip_latch_next, reset_act); // RQ3
	assign first_warn_next = next_first(first_warn_reg, warn_latch_reg,
		warn_latch_next, reset_act); // RQ4

	always_ff @(posedge SYS_CLK) begin
		if (!RESETN) begin
			trip_latch_reg <= `AFSA_EN_RESET;
			warn_latch_reg <= `AFSA_EN_RESET;
			first_trip_reg <= `AFSA_CODE_NONE;
			first_warn_reg <= `AFSA_CODE_NONE;
		end else begin
			trip_latch_reg <= trip_latch_next;
			warn_latch_reg <= warn_latch_next;
			first_trip_reg <= first_trip_next;
			first_warn_reg <= first_warn_next;
		end
	end

	// ------------------------------------------------------------
	// Reported state and outputs
	// ------------------------------------------------------------

	// A latch stays stored if its enable is later cleared, but it is
	// only reported while enabled.
	afsa_pkg::afsa_fault_vec_t trip_report;
	afsa_pkg::afsa_fault_vec_t warn_report;
	logic any_trip;
	logic any_warn;
	logic relay_next;
	logic actuator_next;

	assign trip_report = trip_latch_next & trip_enable_config_reg; // RQ6
	assign warn_report = warn_latch_next & warning_enable_config_reg; // RQ7
	assign any_trip = |trip_report;
	assign any_warn = |warn_report;

	// Energize-for-alarm drives the relay on an alarm; otherwise the
	// relay is held energized and drops out on an alarm.
	assign relay_next = relay_polarity_reg ? any_warn : !any_warn; // RQ12
	assign actuator_next = any_trip || (trip_on_warning_enable_reg && any_warn); // RQ13

	// Outputs load from next values so they change at the same edge as the
	// latches; this keeps pin-to-output latency at three edges.

	always_ff @(posedge SYS_CLK) begin
		if (!RESETN) begin
			TRIP_VIEW <= 1'b0;
			WARN_VIEW <= 1'b0;
			FIRST_TRIP <= `AFSA_CODE_NONE;
			FIRST_WARN <= `AFSA_CODE_NONE;
			TRIP_LATCHED <= `AFSA_EN_RESET;
			WARN_LATCHED <= `AFSA_EN_RESET;
			RELAY2_ENERGIZE <= 1'b0;
			ACTUATOR_SHUTDOWN <= 1'b0;
		end else begin
			TRIP_VIEW <= any_trip; // RQ1
			WARN_VIEW <= any_warn; // RQ2
			FIRST_TRIP <= first_trip_next; // RQ3
			FIRST_WARN <= first_warn_next; // RQ4
			TRIP_LATCHED <= trip_report;
			WARN_LATCHED <= warn_report;
			RELAY2_ENERGIZE <= relay_next; // RQ12
			ACTUATOR_SHUTDOWN <= actuator_next; // RQ13
		end
	end

	// ------------------------------------------------------------
	// Read port
	// ------------------------------------------------------------

	// Each readable word is built on its own wire.
	logic [`AFSA_DATA_W-1:0] word_trip_en;
	logic [`AFSA_DATA_W-1:0] word_warn_en;
	logic [`AFSA_DATA_W-1:0] word_ctrl;
	logic [`AFSA_DATA_W-1:0] word_trip_latch;
	logic [`AFSA_DATA_W-1:0] word_warn_latch;
	logic [`AFSA_DATA_W-1:0] word_first_out;
	logic [`AFSA_DATA_W-1:0] word_live;
	logic [`AFSA_DATA_W-1:0] read_mux;
	logic [`AFSA_DATA_W-1:0] rdata_next;

	assign word_trip_en = fault_word(trip_enable_config_reg);
	assign word_warn_en = fault_word(warning_enable_config_reg);
	assign word_live = fault_word(fault_live);

	// Status words read the registered reports so software sees exactly
	// what the output pins show.
	assign word_trip_latch = fault_word(TRIP_LATCHED);
	assign word_warn_latch = fault_word(WARN_LATCHED);

	// Single-bit fields are packed by position; bits not named here read zero.
	always_comb begin
		word_ctrl = '0;
		word_ctrl[`AFSA_CTRL_RELAY_POL] = relay_polarity_reg;
		word_ctrl[`AFSA_CTRL_TRIP_ON_WARN] = trip_on_warning_enable_reg;
		word_ctrl[`AFSA_CTRL_RESET_CMD] = handheld_reset_reg;
	end

	always_comb begin
		word_first_out = '0;
		word_first_out[`AFSA_FO_TRIP_LSB +: `AFSA_CODE_W] = FIRST_TRIP;
		word_first_out[`AFSA_FO_WARN_LSB +: `AFSA_CODE_W] = FIRST_WARN;
		word_first_out[`AFSA_FO_TRIP_VIEW] = TRIP_VIEW;
		word_first_out[`AFSA_FO_WARN_VIEW] = WARN_VIEW;
	end

	// The select lines are mutually exclusive, so the order of this chain
	// does not matter; unmapped addresses fall through to zero.
	assign read_mux = sel_trip_en ? word_trip_en :
		sel_warn_en ? word_warn_en :
		sel_ctrl ? word_ctrl :
		sel_trip_latch ? word_trip_latch :
		sel_warn_latch ? word_warn_latch :
		sel_first_out ? word_first_out :
		sel_live ? word_live :
		'0;

	// Read data stand only in the cycle after the strobe.
	// A stale word therefore cannot be mistaken for a fresh one.
	assign rdata_next = RD ? read_mux : '0;

	always_ff @(posedge SYS_CLK) begin
		if (!RESETN) begin
			RDATA <= '0;
		end else begin
			RDATA <= rdata_next;
		end
	end

endmodule : afsa_annunciator

/* File: tb/afsa_checker.sv */
// Port-level assertions for the alarm and shutdown annunciator.
`timescale 1ns/100ps
`include "afsa_cfg.svh"
module afsa_checker (
	input wire logic SYS_CLK,
	input wire logic RESETN,
	input wire logic [`AFSA_NUM_FAULTS-1:0] FAULT_IN,
	input wire logic RESET_PIN,
	input wire logic SERIAL_RESET_CMD,
	input wire logic SERVICE_RESET_CMD,
	input wire logic WR,
	input wire logic TRIP_VIEW,
	input wire logic WARN_VIEW,
	input wire logic [`AFSA_CODE_W-1:0] FIRST_TRIP,
	input wire logic [`AFSA_CODE_W-1:0] FIRST_WARN,
	input wire logic [`AFSA_NUM_FAULTS-1:0] TRIP_LATCHED,
	input wire logic [`AFSA_NUM_FAULTS-1:0] WARN_LATCHED,
	input wire logic RELAY2_ENERGIZE,
	input wire logic ACTUATOR_SHUTDOWN
);
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (!RESETN);
	a_trip_view: assert property (TRIP_VIEW == |TRIP_LATCHED)
		else $error("shutdown view disagrees with latches");
	a_warn_view: assert property (WARN_VIEW == |WARN_LATCHED)
		else $error("alarm view disagrees with latches");
	a_first_trip: assert property ($rose(TRIP_VIEW) |-> FIRST_TRIP inside {[1:11]})
		else $error("first shutdown code missing");
	a_first_warn: assert property ($rose(WARN_VIEW) |-> FIRST_WARN inside {[1:11]})
		else $error("first alarm code missing");
	// The relay may only change its sense against the alarm view after a register write.
	a_relay_sense: assert property ($past(RESETN, 2) && !$past(WR) && !$past(WR, 2)
		|-> $stable(RELAY2_ENERGIZE ^ WARN_VIEW)) else $error("relay sense changed alone");
	a_act_on_trip: assert property (TRIP_VIEW |-> ACTUATOR_SHUTDOWN)
		else $error("shutdown did not stop actuator");
	a_act_idle: assert property (!WARN_VIEW |-> ACTUATOR_SHUTDOWN == TRIP_VIEW)
		else $error("actuator stopped without cause");
	a_trip_hold: assert property (($past(TRIP_LATCHED) & ~TRIP_LATCHED) == '0
		|| $past(WR, 2) || $past(WR, 3) || $past(SERIAL_RESET_CMD, 2)
		|| $past(SERVICE_RESET_CMD, 2) || $past(RESET_PIN, 4) || $past(RESET_PIN, 5))
		else $error("shutdown latch dropped without reset");
	a_warn_cause: assert property ((WARN_LATCHED & ~$past(WARN_LATCHED) & ~$past(FAULT_IN, 3))
		== '0 || $past(WR, 2) || $past(WR, 3)) else $error("alarm latched without cause");
endmodule : afsa_checker

bind afsa_annunciator afsa_checker u_checker (
	.SYS_CLK(SYS_CLK),
	.RESETN(RESETN),
	.FAULT_IN(FAULT_IN),
	.RESET_PIN(RESET_PIN),
	.SERIAL_RESET_CMD(SERIAL_RESET_CMD),
	.SERVICE_RESET_CMD(SERVICE_RESET_CMD),
	.WR(WR),
	.TRIP_VIEW(TRIP_VIEW),
	.WARN_VIEW(WARN_VIEW),
	.FIRST_TRIP(FIRST_TRIP),
	.FIRST_WARN(FIRST_WARN),
	.TRIP_LATCHED(TRIP_LATCHED),
	.WARN_LATCHED(WARN_LATCHED),
	.RELAY2_ENERGIZE(RELAY2_ENERGIZE),
	.ACTUATOR_SHUTDOWN(ACTUATOR_SHUTDOWN)
);

/* File: tb/afsa_operator.sv */
// Operator-side model of the discrete reset pin and the two command links.
`timescale 1ns/100ps
module afsa_operator (
	input wire logic clk,
	output logic reset_pin,
	output logic serial_cmd,
	output logic service_cmd
);
	initial begin
		reset_pin = 1'h0;
		serial_cmd = 1'h0;
		service_cmd = 1'h0;
	end
	// One call is one request: raised for a chosen hold, then dropped, so a long
	// hold models a slow operator without ever sending a second request.
	task automatic toggle(input int src, input int hold);
		@(posedge clk);
		case (src)
			0: reset_pin <= 1'h1;
			1: serial_cmd <= 1'h1;
			default: service_cmd <= 1'h1;
		endcase
		repeat (hold) @(posedge clk);
		reset_pin <= 1'h0;
		serial_cmd <= 1'h0;
		service_cmd <= 1'h0;
	endtask : toggle
endmodule : afsa_operator

/* File: tb/tb_alarm_shutdown_annunciator.sv */
// Self-checking bench for the alarm and shutdown annunciator.
`timescale 1ns/100ps
`include "afsa_cfg.svh"
module tb_alarm_shutdown_annunciator;
	logic clk, resetn, wr, rd, rst_pin, ser_cmd, svc_cmd, trip_view, warn_view, relay, act;
	logic [10:0] fault, trip_lat, warn_lat;
	logic [7:0] addr;
	logic [31:0] wdata, rdata;
	logic [3:0] first_trip, first_warn;
	int errors, comparisons, cycles;

	afsa_annunciator DUT (.SYS_CLK(clk), .RESETN(resetn), .FAULT_IN(fault),
		.RESET_PIN(rst_pin), .SERIAL_RESET_CMD(ser_cmd), .SERVICE_RESET_CMD(svc_cmd),
		.ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
		.TRIP_VIEW(trip_view), .WARN_VIEW(warn_view), .FIRST_TRIP(first_trip),
		.FIRST_WARN(first_warn), .TRIP_LATCHED(trip_lat), .WARN_LATCHED(warn_lat),
		.RELAY2_ENERGIZE(relay), .ACTUATOR_SHUTDOWN(act));
	afsa_operator op (.clk(clk), .reset_pin(rst_pin), .serial_cmd(ser_cmd),
		.service_cmd(svc_cmd));

	initial begin
		clk = 1'h0;
		forever #20 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == 2000) begin
			errors++;
			test_done();
		end
	end

	// ----------------------------------------
	// Access and compare tasks
	// ----------------------------------------
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'h1;
		@(posedge clk);
		wr <= 1'h0;
	endtask : wr_reg
	task automatic rd_reg(input logic [7:0] a, input logic [31:0] exp, input string what);
		@(posedge clk);
		addr <= a;
		rd <= 1'h1;
		@(posedge clk);
		rd <= 1'h0;
		#1 chk(what, rdata, exp);
		@(posedge clk);
		#1 chk("read data idle", rdata, 32'h0);
	endtask : rd_reg
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : step
	task automatic set_fault(input logic [10:0] f);
		@(posedge clk);
		fault <= f;
		step(3);
	endtask : set_fault
	task automatic bank(input logic [10:0] tl, input logic [3:0] ft, input logic [10:0] wl,
		input logic [3:0] fw);
		chk("shutdown bank", {trip_view, first_trip, trip_lat}, {|tl, ft, tl});
		chk("alarm bank", {warn_view, first_warn, warn_lat}, {|wl, fw, wl});
	endtask : bank
	task automatic test_done();
		if (errors == 0 && comparisons > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : test_done

	// ----------------------------------------
	// Test sequence
	// ----------------------------------------
	initial begin
		resetn = 1'h0;
		{wr, rd, addr, wdata, fault} = '0;
		repeat (6) @(posedge clk);
		resetn <= 1'h1;
		step(1);
		rd_reg(`AFSA_OFS_TRIP_EN, 32'h0, "shutdown enables");
		rd_reg(`AFSA_OFS_CTRL, 32'h0, "control");
		rd_reg(8'h1C, 32'h0, "unmapped word");
		chk("idle relay", relay, 32'h1);
		wr_reg(`AFSA_OFS_TRIP_EN, 32'h7FF);
		wr_reg(`AFSA_OFS_WARN_EN, 32'h201);
		rd_reg(`AFSA_OFS_WARN_EN, 32'h201, "alarm enables");
		// Two causes in one cycle: the lower code must win the first-out.
		set_fault(11'h204);
		bank(11'h204, 4'h3, 11'h200, 4'hA);
		chk("relay and actuator", {relay, act}, 32'h1);
		rd_reg(`AFSA_OFS_FIRST_OUT, 32'h30A03, "first-out word");
		set_fault(11'h205);
		bank(11'h205, 4'h3, 11'h201, 4'hA);
		rd_reg(`AFSA_OFS_TRIP_LATCH, 32'h205, "shutdown latch word");
		rd_reg(`AFSA_OFS_WARN_LATCH, 32'h201, "alarm latch word");
		rd_reg(`AFSA_OFS_LIVE, 32'h205, "live faults");
		op.toggle(1, 4);
		step(2);
		bank(11'h205, 4'h3, 11'h201, 4'hA);
		set_fault(11'h001);
		op.toggle(2, 1);
		step(2);
		bank(11'h001, 4'h3, 11'h001, 4'hA);
		set_fault(11'h000);
		op.toggle(1, 1);
		step(2);
		bank(11'h0, 4'h0, 11'h0, 4'h0);
		// A one-cycle cause must stay latched until a reset from each source clears it.
		for (int s = 0; s < 4; s++) begin
			@(posedge clk);
			fault <= 11'h400;
			@(posedge clk);
			fault <= 11'h000;
			step(4);
			bank(11'h400, 4'hB, 11'h0, 4'h0);
			if (s == 3) begin
				wr_reg(`AFSA_OFS_CTRL, 32'h4);
				wr_reg(`AFSA_OFS_CTRL, 32'h0);
			end else begin
				op.toggle(s, s + 1);
			end
			step(4);
			bank(11'h0, 4'h0, 11'h0, 4'h0);
		end
		wr_reg(`AFSA_OFS_TRIP_EN, 32'h0);
		wr_reg(`AFSA_OFS_CTRL, 32'h3);
		set_fault(11'h001);
		chk("alarm outputs", {relay, act, trip_view, warn_view}, 32'hD);
		wr_reg(`AFSA_OFS_CTRL, 32'h1);
		step(2);
		chk("alarm without trip", {relay, act}, 32'h2);
		wr_reg(`AFSA_OFS_CTRL, 32'h0);
		step(2);
		chk("relay dropped", {relay, act}, 32'h0);
		// Clearing an enable hides a stored alarm; restoring it shows it again.
		wr_reg(`AFSA_OFS_WARN_EN, 32'h0);
		step(2);
		bank(11'h0, 4'h0, 11'h0, 4'h1);
		wr_reg(`AFSA_OFS_WARN_EN, 32'h201);
		step(2);
		bank(11'h0, 4'h0, 11'h001, 4'h1);
		test_done();
	end
endmodule : tb_alarm_shutdown_annunciator
